/* pkg/ulc_params.svh */
`ifndef ULC_PARAMS_SVH
`define ULC_PARAMS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define ULC_OFF_DATA 8'h00
`define ULC_OFF_DIV_HIGH 8'h04
`define ULC_OFF_LINE_CTRL 8'h08
`define ULC_OFF_LINE_STAT 8'h0C
`define ULC_OFF_IRQ_EN 8'h10
`define ULC_OFF_IRQ_ID 8'h14
`define ULC_OFF_MODEM_STAT 8'h18
`define ULC_OFF_DIV_EXP 8'h1C

// ----------------------------------------------------------------
// line_control fields
// ----------------------------------------------------------------
`define ULC_LC_DSEL 7
`define ULC_LC_BREAK 6
`define ULC_LC_STK 5
`define ULC_LC_EVN 4
`define ULC_LC_PAR 3
`define ULC_LC_STOP 2

// ----------------------------------------------------------------
// irq_enable fields
// ----------------------------------------------------------------
`define ULC_IE_MODEM 3
`define ULC_IE_LINE 2
`define ULC_IE_TX 1
`define ULC_IE_RX 0

// ----------------------------------------------------------------
// irq_identification source codes, bits 2-1
// ----------------------------------------------------------------
`define ULC_IID_LINE 2'h3
`define ULC_IID_RX 2'h2
`define ULC_IID_TX 2'h1
`define ULC_IID_MODEM 2'h0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ULC_RST_LINE_CTRL 8'h03
`define ULC_RST_IRQ_EN 4'h0
`define ULC_RST_DIV_LOW 8'h01
`define ULC_RST_DIV_HIGH 8'h00
`define ULC_RST_DIV_EXP 3'h0

// ----------------------------------------------------------------
// timing, in oversampling ticks (16 per bit)
// ----------------------------------------------------------------
`define ULC_TICK_LAST 6'h0F
`define ULC_TICK_HALF 6'h07
`define ULC_STOP_ONE_LAST 6'h0F
`define ULC_STOP_ONEHALF_LAST 6'h17
`define ULC_STOP_TWO_LAST 6'h1F
`define ULC_BREAK_TICKS 8'hC0

`endif

/* pkg/ulc_pkg.sv */
package ulc_pkg;

  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} ulc_tx_state_type;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} ulc_rx_state_type;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hready;
  } ulc_ahb_req_type;

  typedef struct packed {
    logic dcd;
    logic ri;
    logic dsr;
    logic cts;
  } ulc_modem_type;

  typedef struct packed {
    logic [23:0] cnt;
    logic tick;
  } ulc_baud_state_type;

  typedef struct packed {
    logic [7:0] line_control;
    logic [3:0] irq_enable;
    logic [7:0] div_low;
    logic [7:0] div_high;
    logic [2:0] div_exp;
    logic ph_write;
    logic [7:0] ph_addr;
    logic [31:0] hrdata;
    logic [7:0] tx_hold;
    logic tx_hold_full;
    logic [7:0] tx_shift;
    logic tx_par;
    ulc_tx_state_type tx_state;
    logic [5:0] tx_cnt;
    logic [2:0] tx_bit;
    logic tx_line;
    logic tx_pend;
    logic rxd_meta;
    logic rxd_sync;
    logic rxd_last;
    ulc_rx_state_type rx_state;
    logic [5:0] rx_cnt;
    logic [2:0] rx_bit;
    logic [7:0] rx_shift;
    logic rx_par;
    logic [7:0] rx_buffer;
    logic rx_ready;
    logic overrun;
    logic parity_err;
    logic framing_err;
    logic break_det;
    logic [7:0] brk_cnt;
    logic [3:0] modem_meta;
    logic [3:0] modem_sync;
    logic [3:0] modem_last;
    logic [3:0] modem_delta;
  } ulc_state_type;

endpackage : ulc_pkg

/* rtl/ulc_baud.sv */
`timescale 1ns/10ps
`include "ulc_params.svh"

// oversampling tick: one pulse every 2^exp * 2 * divisor clocks, 16 per bit
module ulc_baud (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [15:0] divisor_i,
  input wire logic [2:0] div_exp_i,
  output logic tick_o
);
  import ulc_pkg::*;

  ulc_baud_state_type s;
  ulc_baud_state_type next_s;
  logic [23:0] limit;

  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  // a zero divisor stops the ticks rather than running at full rate
  always_comb begin
    limit = (24'({divisor_i, 1'b0}) << div_exp_i) - 24'h00_0001;
    next_s = s;
    next_s.tick = 1'b0;
    if (divisor_i == 16'h0000) begin
      next_s.cnt = 24'h00_0000;
    end else if (s.cnt >= limit) begin
      next_s.cnt = 24'h00_0000;
      next_s.tick = 1'b1; // see R22
    end else begin
      next_s.cnt = s.cnt + 24'h00_0001;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick_o = s.tick;

endmodule : ulc_baud

/* rtl/ulc_top.sv */
`timescale 1ns/10ps
`include "ulc_params.svh"

// Summary of operation
// R01: data offset reaches tx_holding/rx_buffer, or divisor_low when divisor_access_sel set.
// R02: force_break holds serial_out low; otherwise the transmitter drives it.
// R03: stick parity sends parity bit equal to even_parity_sel.
// R04: even_parity_sel set means even parity, clear means odd.
// R05: parity_enable adds a parity bit on transmit and checks it on receive.
// R06: stop select gives 1.5 stops for 5-bit words, 2 otherwise; clear gives one.
// R07: receiver checks only the first stop bit.
// R08: char_length_sel 00..11 selects 5..8 data bits both ways.
// R09: tx_empty_flag set while tx_holding empty, cleared by writing it.
// R10: tx_rx_both_empty set when holding and receive buffer both empty.
// R11: break_detect set when serial_in stays low past a longest frame.
// R12: framing_error set on invalid stop bit.
// R13: parity_error set on parity mismatch.
// R14: overrun set when a new character overwrites an unread one.
// R15: rx_data_ready set while rx_buffer holds a character, cleared by reading it.
// R16: modem_irq_en raises interrupt on any modem delta flag.
// R17: line_status_irq_en raises interrupt on break, framing, parity or overrun.
// R18: tx_empty_irq_en raises interrupt when transmit buffer empties.
// R19: rx_full_irq_en raises interrupt when receive buffer fills.
// R20: identification bit0 low when pending, bits 2-1 give highest priority source.
// R21: each source clears on its own read or write as listed.
// R22: baud is core clock over 2^exp, 16, 2 and the 16-bit divisor.
// R23: modem delta flags set on input change (ri only on a high-to-low change), cleared by reading modem_status.
// R24: frame is low start, data LSB first, optional parity, high stops.
// R25: interrupt output follows any pending identification source.
module ulc_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire ulc_pkg::ulc_ahb_req_type bus_i,
  input wire logic [31:0] hwdata_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic serial_in_i,
  output logic serial_out_o,
  input wire ulc_pkg::ulc_modem_type modem_i,
  output logic irq_o
);
  import ulc_pkg::*;

  ulc_state_type s;
  ulc_state_type next_s;
  logic tick;
  logic addr_take;
  logic rd_take;
  logic [7:0] rd_addr;
  logic dsel;
  logic [7:0] line_status;
  logic [7:0] modem_status;
  logic [7:0] iid;
  logic ls_src;
  logic rx_src;
  logic tx_src;
  logic ms_src;
  logic [5:0] stop_last;
  logic [2:0] last_bit;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // parity bit for a character; bits above the length are masked off
  function automatic logic ulc_parity(input logic [7:0] d, input logic [7:0] lc);
    logic [7:0] m;
    m = d & (8'hFF >> (2'h3 - lc[1:0])); // see R08
    if (lc[`ULC_LC_STK]) begin
      return lc[`ULC_LC_EVN]; // see R03
    end
    return lc[`ULC_LC_EVN] ? ^m : ~^m; // see R04
  endfunction : ulc_parity

  // ----------------------------------------------------------------
  // baud tick
  // ----------------------------------------------------------------
  ulc_baud u_baud (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .divisor_i({s.div_high, s.div_low}),
    .div_exp_i(s.div_exp),
    .tick_o(tick)
  );

  // ----------------------------------------------------------------
  // decode and status views
  // ----------------------------------------------------------------
  assign dsel = s.line_control[`ULC_LC_DSEL];
  assign addr_take = bus_i.hsel & bus_i.htrans[1] & bus_i.hready;
  assign rd_take = addr_take & ~bus_i.hwrite;
  assign rd_addr = {bus_i.haddr[7:2], 2'h0};
  assign last_bit = 3'(s.line_control[1:0]) + 3'h4;

  // both status views are computed from present state only
  assign line_status = {1'b0,
                        ~s.tx_hold_full, // see R09
                        ~s.tx_hold_full & ~s.rx_ready, // see R10
                        s.break_det, s.framing_err, s.parity_err, s.overrun,
                        s.rx_ready}; // see R15
  assign modem_status = {s.modem_sync, s.modem_delta};

  // interrupt sources, in priority order
  assign ls_src = s.irq_enable[`ULC_IE_LINE] & |line_status[4:1]; // see R17
  assign rx_src = s.irq_enable[`ULC_IE_RX] & s.rx_ready; // see R19
  assign tx_src = s.irq_enable[`ULC_IE_TX] & s.tx_pend; // see R18
  assign ms_src = s.irq_enable[`ULC_IE_MODEM] & |s.modem_delta; // see R16

  // identification: highest priority pending source wins
  always_comb begin
    iid = 8'h01;
    if (ls_src) begin
      iid = {5'h00, `ULC_IID_LINE, 1'b0}; // see R20
    end else if (rx_src) begin
      iid = {5'h00, `ULC_IID_RX, 1'b0};
    end else if (tx_src) begin
      iid = {5'h00, `ULC_IID_TX, 1'b0};
    end else if (ms_src) begin
      iid = {5'h00, `ULC_IID_MODEM, 1'b0};
    end
  end

  // stop length in ticks
  always_comb begin
    if (!s.line_control[`ULC_LC_STOP]) begin
      stop_last = `ULC_STOP_ONE_LAST; // see R06
    end else if (s.line_control[1:0] == 2'h0) begin
      stop_last = `ULC_STOP_ONEHALF_LAST;
    end else begin
      stop_last = `ULC_STOP_TWO_LAST;
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // clears from the bus are applied first so that a hardware set later
  // in the same cycle always wins over a software clear
  always_comb begin
    next_s = s;

    // write data phase, one cycle after the address phase
    if (s.ph_write) begin
      unique case (s.ph_addr)
        `ULC_OFF_DATA: begin
          if (dsel) begin
            next_s.div_low = hwdata_i[7:0]; // see R01
          end else begin
            next_s.tx_hold = hwdata_i[7:0];
            next_s.tx_hold_full = 1'b1; // see R09
            next_s.tx_pend = 1'b0; // see R21
          end
        end
        `ULC_OFF_DIV_HIGH: begin
          if (dsel) begin
            next_s.div_high = hwdata_i[7:0]; // see R01
          end
        end
        `ULC_OFF_LINE_CTRL: next_s.line_control = hwdata_i[7:0];
        `ULC_OFF_IRQ_EN: next_s.irq_enable = hwdata_i[3:0];
        `ULC_OFF_DIV_EXP: next_s.div_exp = hwdata_i[2:0];
        default: ;
      endcase
    end
    next_s.ph_write = addr_take & bus_i.hwrite;
    next_s.ph_addr = rd_addr;

    // read address phase: capture data and apply read side effects
    next_s.hrdata = 32'h0000_0000;
    if (rd_take) begin
      unique case (rd_addr)
        `ULC_OFF_DATA: begin
          if (dsel) begin
            next_s.hrdata = {24'h00_0000, s.div_low}; // see R01
          end else begin
            next_s.hrdata = {24'h00_0000, s.rx_buffer};
            next_s.rx_ready = 1'b0; // see R15
          end
        end
        `ULC_OFF_DIV_HIGH: next_s.hrdata = dsel ? {24'h00_0000, s.div_high} : 32'h0000_0000;
        `ULC_OFF_LINE_CTRL: next_s.hrdata = {24'h00_0000, s.line_control};
        `ULC_OFF_LINE_STAT: begin
          next_s.hrdata = {24'h00_0000, line_status};
          next_s.break_det = 1'b0; // see R11
          next_s.framing_err = 1'b0; // see R12
          next_s.parity_err = 1'b0; // see R13
          next_s.overrun = 1'b0; // see R14
        end
        `ULC_OFF_IRQ_EN: next_s.hrdata = {28'h000_0000, s.irq_enable};
        `ULC_OFF_IRQ_ID: begin
          next_s.hrdata = {24'h00_0000, iid};
          if (iid[2:1] == `ULC_IID_TX && !iid[0]) begin
            next_s.tx_pend = 1'b0; // see R21
          end
        end
        `ULC_OFF_MODEM_STAT: begin
          next_s.hrdata = {24'h00_0000, modem_status};
          next_s.modem_delta = 4'h0; // see R23
        end
        `ULC_OFF_DIV_EXP: next_s.hrdata = {29'h0000_0000, s.div_exp};
        default: ;
      endcase
    end

    // transmitter
    unique case (s.tx_state)
      TX_IDLE: begin
        next_s.tx_line = 1'b1; // see R24
        if (next_s.tx_hold_full) begin
          next_s.tx_shift = next_s.tx_hold;
          next_s.tx_par = ulc_parity(next_s.tx_hold, s.line_control);
          next_s.tx_hold_full = 1'b0;
          next_s.tx_pend = 1'b1; // see R18
          next_s.tx_line = 1'b0; // see R24
          next_s.tx_cnt = 6'h00;
          next_s.tx_state = TX_START;
        end
      end
      TX_START: begin
        if (tick) begin
          next_s.tx_cnt = s.tx_cnt + 6'h01;
          if (s.tx_cnt == `ULC_TICK_LAST) begin
            next_s.tx_cnt = 6'h00;
            next_s.tx_bit = 3'h0;
            next_s.tx_line = s.tx_shift[0]; // see R24
            next_s.tx_state = TX_DATA;
          end
        end
      end
      TX_DATA: begin
        if (tick) begin
          next_s.tx_cnt = s.tx_cnt + 6'h01;
          if (s.tx_cnt == `ULC_TICK_LAST) begin
            next_s.tx_cnt = 6'h00;
            if (s.tx_bit == last_bit) begin // see R08
              if (s.line_control[`ULC_LC_PAR]) begin
                next_s.tx_line = s.tx_par; // see R05
                next_s.tx_state = TX_PARITY;
              end else begin
                next_s.tx_line = 1'b1;
                next_s.tx_state = TX_STOP;
              end
            end else begin
              next_s.tx_shift = {1'b0, s.tx_shift[7:1]};
              next_s.tx_line = s.tx_shift[1];
              next_s.tx_bit = s.tx_bit + 3'h1;
            end
          end
        end
      end
      TX_PARITY: begin
        if (tick) begin
          next_s.tx_cnt = s.tx_cnt + 6'h01;
          if (s.tx_cnt == `ULC_TICK_LAST) begin
            next_s.tx_cnt = 6'h00;
            next_s.tx_line = 1'b1;
            next_s.tx_state = TX_STOP;
          end
        end
      end
      TX_STOP: begin
        if (tick) begin
          next_s.tx_cnt = s.tx_cnt + 6'h01;
          if (s.tx_cnt >= stop_last) begin // see R06
            next_s.tx_cnt = 6'h00;
            next_s.tx_state = TX_IDLE;
          end
        end
      end
      default: next_s.tx_state = TX_IDLE;
    endcase

    // receive pin synchroniser; only rxd_sync is looked at
    next_s.rxd_meta = serial_in_i;
    next_s.rxd_sync = s.rxd_meta;

    // break: count ticks of continuous low line
    if (tick) begin
      if (s.rxd_sync) begin
        next_s.brk_cnt = 8'h00;
      end else if (s.brk_cnt < `ULC_BREAK_TICKS) begin
        next_s.brk_cnt = s.brk_cnt + 8'h01;
      end else begin
        next_s.break_det = 1'b1; // see R11
      end
    end

    // receiver; a start needs a high-to-low edge, so a held break
    // yields one character and then waits for the line to rise
    if (tick) begin
      next_s.rxd_last = s.rxd_sync;
    end
    unique case (s.rx_state)
      RX_IDLE: begin
        if (tick && s.rxd_last && !s.rxd_sync) begin // see R24
          next_s.rx_cnt = 6'h00;
          next_s.rx_state = RX_START;
        end
      end
      RX_START: begin
        if (tick) begin
          next_s.rx_cnt = s.rx_cnt + 6'h01;
          if (s.rx_cnt == `ULC_TICK_HALF) begin
            next_s.rx_cnt = 6'h00;
            next_s.rx_bit = 3'h0;
            next_s.rx_shift = 8'h00;
            // a glitch shorter than half a bit is dropped
            next_s.rx_state = s.rxd_sync ? RX_IDLE : RX_DATA;
          end
        end
      end
      RX_DATA: begin
        if (tick) begin
          next_s.rx_cnt = s.rx_cnt + 6'h01;
          if (s.rx_cnt == `ULC_TICK_LAST) begin
            next_s.rx_cnt = 6'h00;
            next_s.rx_shift[s.rx_bit] = s.rxd_sync; // see R24
            next_s.rx_bit = s.rx_bit + 3'h1;
            if (s.rx_bit == last_bit) begin // see R08
              next_s.rx_state = s.line_control[`ULC_LC_PAR] ? RX_PARITY : RX_STOP;
            end
          end
        end
      end
      RX_PARITY: begin
        if (tick) begin
          next_s.rx_cnt = s.rx_cnt + 6'h01;
          if (s.rx_cnt == `ULC_TICK_LAST) begin
            next_s.rx_cnt = 6'h00;
            next_s.rx_par = s.rxd_sync;
            next_s.rx_state = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (tick) begin
          next_s.rx_cnt = s.rx_cnt + 6'h01;
          if (s.rx_cnt == `ULC_TICK_LAST) begin
            next_s.rx_cnt = 6'h00;
            next_s.rx_buffer = s.rx_shift;
            // a read in this same cycle empties the buffer first
            if (next_s.rx_ready) begin
              next_s.overrun = 1'b1; // see R14
            end
            next_s.rx_ready = 1'b1; // see R15
            if (!s.rxd_sync) begin
              next_s.framing_err = 1'b1; // see R07
            end
            if (s.line_control[`ULC_LC_PAR] &&
                s.rx_par != ulc_parity(s.rx_shift, s.line_control)) begin
              next_s.parity_err = 1'b1; // see R13
            end
            next_s.rx_state = RX_IDLE;
          end
        end
      end
      default: next_s.rx_state = RX_IDLE;
    endcase

    // modem inputs: two-stage sync, then change detect
    next_s.modem_meta = modem_i;
    next_s.modem_sync = s.modem_meta;
    next_s.modem_last = s.modem_sync;
    if (s.modem_sync[3] != s.modem_last[3]) begin
      next_s.modem_delta[3] = 1'b1; // see R23
    end
    if (!s.modem_sync[2] && s.modem_last[2]) begin
      next_s.modem_delta[2] = 1'b1; // see R23
    end
    if (s.modem_sync[1] != s.modem_last[1]) begin
      next_s.modem_delta[1] = 1'b1; // see R23
    end
    if (s.modem_sync[0] != s.modem_last[0]) begin
      next_s.modem_delta[0] = 1'b1; // see R23
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
      s.line_control <= `ULC_RST_LINE_CTRL;
      s.irq_enable <= `ULC_RST_IRQ_EN;
      s.div_low <= `ULC_RST_DIV_LOW;
      s.div_high <= `ULC_RST_DIV_HIGH;
      s.div_exp <= `ULC_RST_DIV_EXP;
      s.tx_state <= TX_IDLE;
      s.rx_state <= RX_IDLE;
      s.tx_line <= 1'b1;
      s.rxd_meta <= 1'b1;
      s.rxd_sync <= 1'b1;
      s.rxd_last <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // zero wait states: data always ready one cycle after the address
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = s.hrdata;
  assign serial_out_o = s.tx_line & ~s.line_control[`ULC_LC_BREAK]; // see R02
  assign irq_o = ~iid[0]; // see R25

endmodule : ulc_top

/* tb/tb.sv */
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; $display("[FAIL] %0t got %h", $time, g); end end
module tb;
  import ulc_pkg::*;
  logic clk_i, rst_i, hready, hresp, rxd, txd, irq;
  ulc_ahb_req_type bus;
  logic [31:0] hwdata, hrdata, r;
  ulc_modem_type modem;
  int failures, checks_done;
  ulc_top dut_u (.clk_i, .rst_i, .bus_i({bus[39:1], hready}), .hwdata_i(hwdata), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .serial_in_i(rxd), .serial_out_o(txd), .modem_i(modem), .irq_o(irq));
  ulc_remote rem_u (.clk_i, .line_i(txd), .line_o(rxd));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // ----
  // bus cycles
  // ----
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    bus.htrans <= 2'h2;
    bus.hwrite <= w;
    bus.haddr <= {24'h0, a};
    do @(posedge clk_i); while (hready !== 1'b1);
    bus.htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge clk_i); while (hready !== 1'b1);
    r = hrdata;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic rr(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    `CHK(r[7:0], e)
  endtask : rr
  // expected frame slots and start-to-start spacing in clocks
  function automatic void expf(input logic [7:0] c, input logic [7:0] d, output logic [11:0] e,
    output int n, output int g);
    int nb;
    nb = 5 + c[1:0];
    e = '0;
    for (int i = 0; i < nb; i++) e[1 + i] = d[i];
    if (c[3]) e[nb + 1] = c[5] ? c[4] : ^(d & (8'hFF >> (8 - nb))) ^ !c[4];
    n = nb + 1 + c[3];
    e[n] = 1'b1;
    g = 16 * (2 * n + (c[2] ? (nb == 5 ? 3 : 4) : 2));
    n = n + 1;
  endfunction : expf
  // ----
  // scenarios
  // ----
  task automatic t_reset;
    rr(8'h08, 8'h03);
    rr(8'h0C, 8'h60);
    rr(8'h14, 8'h01);
    rr(8'h04, 8'h00);
    rr(8'h20, 8'h00);
    `CHK(hresp, 1'b0)
  endtask : t_reset
  task automatic t_tx;
    logic [7:0] c [5] = '{8'h00, 8'h0D, 8'h1E, 8'h3F, 8'h2C};
    logic [7:0] d;
    logic [11:0] f1, f2, e1, e2;
    int n, g, t1, t2;
    for (int k = 0; k < 5; k++) begin
      d = 8'hB4 ^ 8'(k * 37);
      wr(8'h08, c[k]);
      expf(c[k], d, e1, n, g);
      expf(c[k], ~d, e2, n, g);
      fork
        rem_u.catch(n, f1, t1);
        begin
          wr(8'h00, d);
          wr(8'h00, ~d);
          rr(8'h0C, 8'h00);
        end
      join
      rem_u.catch(n, f2, t2);
      rr(8'h0C, 8'h60);
      `CHK(f1, e1)
      `CHK(f2, e2)
      `CHK((t2 - t1 - g) inside {[-3:3]}, 1'b1)
      repeat (64) @(posedge clk_i);
    end
  endtask : t_tx
  task automatic t_rx;
    wr(8'h08, 8'h03);
    wr(8'h10, 8'h05);
    rem_u.send(8'h5A, -1, 1'b1);
    repeat (4) @(posedge clk_i);
    `CHK(irq, 1'b1)
    rr(8'h14, 8'h04);
    rr(8'h0C, 8'h41);
    rr(8'h00, 8'h5A);
    rr(8'h14, 8'h01);
    rem_u.send(8'h11, -1, 1'b1);
    rem_u.send(8'h22, -1, 1'b1);
    repeat (4) @(posedge clk_i);
    rr(8'h14, 8'h06);
    rr(8'h0C, 8'h43);
    rr(8'h14, 8'h04);
    rr(8'h00, 8'h22);
    wr(8'h08, 8'h1F);
    rem_u.send(8'h0F, 0, 1'b1);
    rem_u.send(8'h03, 1, 1'b1);
    repeat (4) @(posedge clk_i);
    rr(8'h0C, 8'h47);
    rr(8'h00, 8'h03);
    rem_u.send(8'h00, 0, 1'b0);
    repeat (4) @(posedge clk_i);
    rr(8'h0C, 8'h49);
    rr(8'h00, 8'h00);
    rem_u.low(450);
    repeat (4) @(posedge clk_i);
    rr(8'h0C, 8'h59);
    rr(8'h00, 8'h00);
  endtask : t_rx
  task automatic t_irq;
    wr(8'h08, 8'h03);
    wr(8'h10, 8'h02);
    wr(8'h00, 8'h55);
    repeat (4) @(posedge clk_i);
    rr(8'h14, 8'h02);
    rr(8'h14, 8'h01);
    repeat (400) @(posedge clk_i);
    xfer(1'b0, 8'h18, 8'h00);
    wr(8'h10, 8'h08);
    modem <= 4'hE;
    repeat (4) @(posedge clk_i);
    `CHK(irq, 1'b1)
    rr(8'h14, 8'h00);
    rr(8'h18, 8'hE1);
    rr(8'h14, 8'h01);
    `CHK(irq, 1'b0)
  endtask : t_irq
  task automatic t_baud;
    int n;
    wr(8'h08, 8'h43);
    @(posedge clk_i);
    `CHK(txd, 1'b0)
    wr(8'h08, 8'h80);
    wr(8'h00, 8'h02);
    rr(8'h00, 8'h02);
    wr(8'h1C, 8'h01);
    wr(8'h08, 8'h00);
    wr(8'h00, 8'h00);
    n = 0;
    do @(posedge clk_i); while (txd);
    while (!txd) begin
      @(posedge clk_i);
      n++;
    end
    `CHK(n inside {[758:778]}, 1'b1)
  endtask : t_baud
  task automatic complete_run;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  // a hang counts as a mismatch
  initial begin
    repeat (60000) @(posedge clk_i);
    failures++;
    complete_run();
  end
  initial begin
    rst_i = 1'b1;
    bus = {1'b1, 32'h0000_0000, 2'h0, 1'b0, 3'h2, 1'b0};
    hwdata = 32'h0000_0000;
    modem = 4'hF;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_tx();
    t_rx();
    t_irq();
    t_baud();
    complete_run();
  end
endmodule : tb

/* tb/ulc_remote.sv */
`timescale 1ns/10ps
// far-side serial device; one bit lasts BITC clocks
module ulc_remote #(
  parameter int BITC = 32
) (
  input wire logic clk_i,
  input wire logic line_i,
  output logic line_o
);
  int cyc = 0;
  initial line_o = 1'b1;
  always @(posedge clk_i) cyc <= cyc + 1;
  // low start, lsb first, optional parity, one stop, then idle high
  task automatic send(input logic [7:0] d, input int pb, input logic stp);
    for (int i = -1; i < 10; i++) begin
      if (i == 8 && pb < 0) continue;
      line_o <= i < 0 ? 1'b0 : i < 8 ? d[i] : i == 8 ? pb[0] : stp;
      repeat (BITC) @(posedge clk_i);
    end
    line_o <= 1'b1;
  endtask : send
  // hold the line low, as a break does
  task automatic low(input int n);
    line_o <= 1'b0;
    repeat (n) @(posedge clk_i);
    line_o <= 1'b1;
  endtask : low
  // mid-bit sampling from the start edge; stops at the first stop bit
  task automatic catch(input int n, output logic [11:0] f, output int t);
    f = '0;
    do @(posedge clk_i); while (line_i);
    t = cyc;
    for (int i = 0; i < n; i++) begin
      repeat (i > 0 ? BITC : BITC / 2) @(posedge clk_i);
      f[i] = line_i;
    end
  endtask : catch
endmodule : ulc_remote

/* tb/ulc_top_props.sv */
`timescale 1ns/10ps
module ulc_top_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire ulc_pkg::ulc_ahb_req_type bus_i,
  input wire logic [31:0] hwdata_i,
  input wire logic [31:0] hrdata_o,
  input wire logic serial_out_o,
  input wire logic irq_o
);
  import ulc_pkg::*;
  // ----
  // shadow of written control bits
  // ----
  logic rd, wp;
  logic [7:0] a, wa, lc_q;
  logic [3:0] ie_q;
  assign a = bus_i.haddr[7:0];
  assign rd = bus_i.hsel && bus_i.htrans[1] && bus_i.hready && !bus_i.hwrite;
  // writes land at the data-phase edge, the same edge as in the block
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wp <= 1'b0;
      wa <= 8'h00;
      lc_q <= 8'h03;
      ie_q <= 4'h0;
    end else begin
      wp <= bus_i.hsel && bus_i.htrans[1] && bus_i.hready && bus_i.hwrite;
      wa <= a;
      if (wp && wa == 8'h08) lc_q <= hwdata_i[7:0];
      if (wp && wa == 8'h10) ie_q <= hwdata_i[3:0];
    end
  end
  // ----
  // properties
  // ----
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  break_low_a:
    assert property (lc_q[6] |-> !serial_out_o) else $error("break not low");
  start_hold_a:
    assert property ($fell(serial_out_o) && !lc_q[6] |-> !serial_out_o [*8]) else $error("short start");
  iid_irq_a:
    assert property (rd && a == 8'h14 |=> hrdata_o[0] == !$past(irq_o) && (!hrdata_o[0] || hrdata_o[2:1] == 2'h0))
    else $error("iid vs irq");
  lc_read_a:
    assert property (rd && a == 8'h08 |=> hrdata_o[7:0] == $past(lc_q)) else $error("lc readback");
  hidden_div_a:
    assert property (rd && a == 8'h04 && !lc_q[7] |=> hrdata_o == 32'h0000_0000) else $error("div visible");
  quiet_bus_a:
    assert property (!rd |=> hrdata_o == 32'h0000_0000) else $error("stray rdata");
  irq_enabled_a:
    assert property ($rose(irq_o) |-> ie_q != 4'h0) else $error("irq unmasked");
  irq_none_a:
    assert property (ie_q == 4'h0 |-> !irq_o) else $error("irq with none enabled");
  lsr_empty_a:
    assert property (rd && a == 8'h0C |=> !hrdata_o[5] || (hrdata_o[6] && !hrdata_o[0])) else $error("both empty");
endmodule : ulc_top_props

bind ulc_top ulc_top_props chk_u (.clk_i, .rst_i, .bus_i, .hwdata_i, .hrdata_o, .serial_out_o, .irq_o);
